// File: src/ulp_pkg.sv
// ulp_pkg: register indices, field positions and helpers of the serial block.
// assumes 16-bit registers reached word-wise at four times their index.
`default_nettype none
package ulp_pkg;
	// printed register indices, port 1 then port 2
	localparam logic [11:0] IDX_MODE1 = 12'h20c;
	localparam logic [11:0] IDX_STA1  = 12'h20e;
	localparam logic [11:0] IDX_TX1   = 12'h210;
	localparam logic [11:0] IDX_RX1   = 12'h212;
	localparam logic [11:0] IDX_BRG1  = 12'h214;
	localparam logic [11:0] IDX_MODE2 = 12'h216;
	localparam logic [11:0] IDX_STA2  = 12'h218;
	localparam logic [11:0] IDX_TX2   = 12'h21a;
	localparam logic [11:0] IDX_RX2   = 12'h21c;
	localparam logic [11:0] IDX_BRG2  = 12'h21e;
	// interrupt status and mask
	localparam logic [11:0] IDX_STAT  = 12'h220;
	localparam logic [11:0] IDX_MASK  = 12'h221;
	// register kinds within one port, in the order of the indices
	localparam logic [2:0] K_MODE = 3'h0;
	localparam logic [2:0] K_STA  = 3'h1;
	localparam logic [2:0] K_TX   = 3'h2;
	localparam logic [2:0] K_RX   = 3'h3;
	localparam logic [2:0] K_BRG  = 3'h4;
	localparam logic [2:0] K_STAT = 3'h5;
	localparam logic [2:0] K_MASK = 3'h6;
	// mode control fields
	localparam int MODE_EN   = 15;
	localparam int MODE_SIDL = 13;
	localparam int MODE_WAKE = 7;
	localparam int MODE_LPBK = 6;
	localparam int MODE_PD   = 1;
	localparam int MODE_ST   = 0;
	// line status fields
	localparam int STA_BRK   = 11;
	localparam int STA_TXEN  = 10;
	localparam int STA_TXBF  = 9;
	localparam int STA_SHIFTER_EMPTY_FLAG  = 8;
	localparam int STA_RXSEL = 6;
	localparam int STA_ADDRESS_MATCH_ENABLE = 5;
	localparam int STA_RECEIVER_QUIET_FLAG = 4;
	localparam int STA_PARITY_FAULT_FLAG  = 3;
	localparam int STA_STOP_BIT_FAULT_FLAG  = 2;
	localparam int STA_RX_OVERFLOW_FLAG  = 1;
	localparam int STA_RXDA  = 0;
	// writable bits and reset values
	localparam logic [15:0] MODE_WMASK = 16'ha0e7;
	localparam logic [15:0] STA_WMASK  = 16'h8ce0;
	localparam logic [15:0] BRG_WMASK  = 16'hffff;
	localparam logic [15:0] REG_RST    = 16'h0000;
	localparam logic [15:0] STA_RST    = 16'h0110;
	// sixteen sub-ticks per bit, sampled in the middle
	localparam logic [3:0] OVS_LAST   = 4'hf;
	localparam logic [3:0] OVS_MID    = 4'h7;
	localparam logic [3:0] FRAME_BASE = 4'ha;
	localparam logic [3:0] IRQ_RX     = 4'h3;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic       hit;
		logic       p;
		logic [2:0] kind;
	} ulp_dec_t;

	// bit after the eight data bits: parity, ninth data bit or idle one
	function automatic logic ninth(input logic [1:0] pd,
		input logic [8:0] d);
		unique case (pd)
			2'b00: ninth = 1'b1;
			2'b01: ninth = ^d[7:0];
			2'b10: ninth = ~^d[7:0];
			2'b11: ninth = d[8];
		endcase
	endfunction

	// bits per frame, start and stop bits included
	function automatic logic [3:0] frame_len(input logic [1:0] pd,
		input logic st);
		frame_len = FRAME_BASE + {3'h0, pd != 2'b00} + {3'h0, st};
	endfunction
endpackage
`default_nettype wire

// File: src/ulp_brg.sv
// ulp_brg: bit-rate divider giving sixteen ticks per bit.
// assumes run is low whenever the block's clocks are to stand still.
`default_nettype none
module ulp_brg (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        run,
	input  wire logic [15:0] divisor,
	output var  logic        tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} ulp_brg_t;
	ulp_brg_t s_ff;
	ulp_brg_t nxt_s;

	// one tick every divisor+1 clocks, held low when stopped
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (!run) begin
			nxt_s.cnt = 16'h0000;
		end else if (s_ff.cnt == divisor) begin
			nxt_s.cnt = 16'h0000;
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.cnt = s_ff.cnt + 16'h0001;
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign tick = s_ff.tick;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rate;
		(run && s_ff.cnt == divisor) |=> tick;
	endproperty
	a_rate: assert property (p_rate) else $error("divider tick missing");
	property p_stop;
		!run |=> !tick ##1 ($past(run) || !tick);
	endproperty
	a_stop: assert property (p_stop) else $error("tick while stopped");
	c_tick: cover property (run && tick);
endmodule
`default_nettype wire

// File: src/ulp_tx.sv
// ulp_tx: one-word send buffer and shifter of one port.
// assumes tick comes from ulp_brg and wr is a one-cycle pulse.
`default_nettype none
module ulp_tx (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic       tx_path_enable,
	input  wire logic       tx_line_hold_low,
	input  wire logic [1:0] pd,
	input  wire logic       st,
	input  wire logic       wr,
	input  wire logic [8:0] wd,
	output var  logic       line,
	output var  logic       full,
	output var  logic       empty,
	output var  logic       load,
	output var  logic [8:0] hold
);
	typedef struct packed {
		logic [8:0]  hold;
		logic        full;
		logic [11:0] sh;
		logic [3:0]  left;
		logic [3:0]  sub;
		logic        act;
		logic        load;
		logic        line;
	} ulp_tx_t;
	ulp_tx_t s_ff;
	ulp_tx_t nxt_s;

	// shift out lsb first; stop aborts the frame but keeps the buffer
	always_comb begin
		nxt_s = s_ff;
		nxt_s.load = 1'b0;
		if (!run) begin
			nxt_s.act = 1'b0;
			nxt_s.sub = 4'h0;
		end else begin
			if (s_ff.act && tick) begin
				nxt_s.sub = s_ff.sub + 4'h1;
				if (s_ff.sub == ulp_pkg::OVS_LAST) begin
					nxt_s.sh = {1'b1, s_ff.sh[11:1]};
					nxt_s.left = s_ff.left - 4'h1;
					nxt_s.act = s_ff.left != 4'h1;
				end
			end
			if (!nxt_s.act && s_ff.full && tx_path_enable &&
				!tx_line_hold_low) begin
				nxt_s.sh = {2'b11, ulp_pkg::ninth(pd, s_ff.hold),
					s_ff.hold[7:0], 1'b0};
				nxt_s.left = ulp_pkg::frame_len(pd, st);
				nxt_s.sub = 4'h0;
				nxt_s.act = 1'b1;
				nxt_s.full = 1'b0;
				nxt_s.load = 1'b1;
			end
		end
		// a write to a full buffer is dropped
		if (wr && !s_ff.full) begin
			nxt_s.hold = wd;
			nxt_s.full = 1'b1;
		end
		if (!run) begin
			nxt_s.line = 1'b1;
		end else if (tx_line_hold_low) begin
			nxt_s.line = 1'b0;
		end else begin
			nxt_s.line = nxt_s.act ? nxt_s.sh[0] : 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
			s_ff.line <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign line = s_ff.line;
	assign full = s_ff.full;
	assign empty = !s_ff.full && !s_ff.act;
	assign load = s_ff.load;
	assign hold = s_ff.hold;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_abort;
		!run |=> !s_ff.act;
	endproperty
	a_abort: assert property (p_abort) else $error("frame kept running");
	property p_high;
		!run |=> line;
	endproperty
	a_high: assert property (p_high) else $error("line low while stopped");
	c_load: cover property (load);
endmodule
`default_nettype wire

// File: src/ulp_uart_top.sv
// ulp_uart_top: two serial ports with AXI4-Lite registers and interrupt.
// assumes SLEEP and CPU_IDLE are synchronous levels from the power logic.
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none
module ulp_uart_top (
	input  wire logic        REF_CLK,
	input  wire logic        ARST_N,
	input  wire logic        SLEEP,
	input  wire logic        CPU_IDLE,
	input  wire logic [1:0]  SERIAL_IN_LINE,
	output var  logic [1:0]  SERIAL_OUT_LINE,
	output var  logic        IRQ,
	output var  logic        WAKE_REQ,
	input  wire logic [13:0] AWADDR,
	input  wire logic        AWVALID,
	output var  logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output var  logic        WREADY,
	output var  logic [1:0]  BRESP,
	output var  logic        BVALID,
	input  wire logic        BREADY,
	input  wire logic [13:0] ARADDR,
	input  wire logic        ARVALID,
	output var  logic        ARREADY,
	output var  logic [31:0] RDATA,
	output var  logic [1:0]  RRESP,
	output var  logic        RVALID,
	input  wire logic        RREADY
);
	typedef struct packed {
		logic             aw_got;
		logic             w_got;
		logic [11:0]      aw_idx;
		logic [15:0]      wd;
		logic [1:0]       ws;
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             r_tx;
		logic [1:0][15:0] mode;
		logic [1:0][15:0] sta;
		logic [1:0][15:0] brg;
		logic [1:0][8:0]  rxw;
		logic [1:0]       parity_fault_flag;
		logic [1:0]       stop_bit_fault_flag;
		logic [1:0]       rx_overflow_flag;
		logic [1:0]       rxda;
		logic [1:0]       act;
		logic [1:0]       whi;
		logic [1:0]       prev;
		logic [1:0]       txwr;
		logic [1:0][8:0]  txd;
		logic [1:0][3:0]  sub;
		logic [1:0][3:0]  bitn;
		logic [1:0][11:0] sh;
		logic [3:0]       stat;
		logic [3:0]       mask;
		logic             irq;
		logic             wake;
	} ulp_top_t;
	ulp_top_t s_ff;
	ulp_top_t nxt_s;

	logic [1:0]       run;
	logic [1:0]       tick;
	logic [1:0]       tx_line;
	logic [1:0]       tx_full;
	logic [1:0]       tx_empty;
	logic [1:0]       tx_load;
	logic [1:0][8:0]  tx_hold;
	logic             wr_commit;
	ulp_pkg::ulp_dec_t wdec;

	// find port and register kind of an index
	function automatic ulp_pkg::ulp_dec_t dec(input logic [11:0] idx);
		logic [11:0] base;
		logic [11:0] off;
		dec = '0;
		base = 12'h000;
		off = 12'h000;
		if (idx == ulp_pkg::IDX_STAT) begin
			dec.hit = 1'b1;
			dec.kind = ulp_pkg::K_STAT;
		end else if (idx == ulp_pkg::IDX_MASK) begin
			dec.hit = 1'b1;
			dec.kind = ulp_pkg::K_MASK;
		end else begin
			for (int p = 0; p < 2; p++) begin
				base = (p == 0) ? ulp_pkg::IDX_MODE1 : ulp_pkg::IDX_MODE2;
				off = idx - base;
				if (idx >= base && off <= ulp_pkg::IDX_BRG1 -
					ulp_pkg::IDX_MODE1 && !off[0]) begin
					dec.hit = 1'b1;
					dec.p = p[0];
					dec.kind = off[3:1];
				end
			end
		end
	endfunction

	// byte-lane merge of a write into the writable bits
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] ws,
		input logic [15:0] wmask);
		logic [15:0] lane;
		lane = {{8{ws[1]}}, {8{ws[0]}}} & wmask;
		merge = (old & ~lane) | (wd & lane);
	endfunction

	// port runs when enabled, awake, and not halted by cpu idle
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			run[i] = s_ff.mode[i][ulp_pkg::MODE_EN] && !SLEEP &&
				!(CPU_IDLE && s_ff.mode[i][ulp_pkg::MODE_SIDL]);
		end
	end
	assign wr_commit = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
	assign wdec = dec(s_ff.aw_idx);

	// bit-rate dividers and send paths, one of each per port
	for (genvar g = 0; g < 2; g++) begin : g_port
		ulp_brg u_brg (
			.clk     (REF_CLK),
			.arst_n  (ARST_N),
			.run     (run[g]),
			.divisor (s_ff.brg[g]),
			.tick    (tick[g])
		);
		ulp_tx u_tx (
			.clk              (REF_CLK),
			.arst_n           (ARST_N),
			.run              (run[g]),
			.tick             (tick[g]),
			.tx_path_enable   (s_ff.sta[g][ulp_pkg::STA_TXEN]),
			.tx_line_hold_low (s_ff.sta[g][ulp_pkg::STA_BRK]),
			.pd               (s_ff.mode[g][ulp_pkg::MODE_PD +: 2]),
			.st               (s_ff.mode[g][ulp_pkg::MODE_ST]),
			.wr               (s_ff.txwr[g]),
			.wd               (s_ff.txd[g]),
			.line             (tx_line[g]),
			.full             (tx_full[g]),
			.empty            (tx_empty[g]),
			.load             (tx_load[g]),
			.hold             (tx_hold[g])
		);
	end

	// bus slave, register file, receivers and interrupt logic
	always_comb begin
		ulp_pkg::ulp_dec_t d;
		logic [15:0] v;
		logic [11:0] w;
		logic [8:0]  data;
		logic [3:0]  len;
		logic [1:0]  pd;
		logic        src;
		logic        evt;
		d = '0;
		v = 16'h0000;
		w = 12'h000;
		data = 9'h000;
		len = 4'h0;
		pd = 2'b00;
		src = 1'b1;
		evt = 1'b0;
		nxt_s = s_ff;
		nxt_s.txwr = 2'b00;
		if (s_ff.bvalid && BREADY) begin
			nxt_s.bvalid = 1'b0;
		end
		if (s_ff.rvalid && RREADY) begin
			nxt_s.rvalid = 1'b0;
		end
		if (AWVALID && s_ff.awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_idx = AWADDR[13:2];
		end
		if (WVALID && s_ff.wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wd = WDATA[15:0];
			nxt_s.ws = WSTRB[1:0];
		end
		// write commit once address and data are both held
		if (wr_commit) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = wdec.hit ? ulp_pkg::RESP_OKAY :
				ulp_pkg::RESP_SLVERR;
			if (wdec.hit) begin
				unique case (wdec.kind)
					ulp_pkg::K_MODE: nxt_s.mode[wdec.p] = merge(
						s_ff.mode[wdec.p], s_ff.wd, s_ff.ws,
						ulp_pkg::MODE_WMASK);
					ulp_pkg::K_STA: begin
						nxt_s.sta[wdec.p] = merge(s_ff.sta[wdec.p],
							s_ff.wd, s_ff.ws, ulp_pkg::STA_WMASK);
						if (s_ff.ws[0] && !s_ff.wd[ulp_pkg::STA_RX_OVERFLOW_FLAG]) begin
							nxt_s.rx_overflow_flag[wdec.p] = 1'b0;
						end
					end
					ulp_pkg::K_TX: begin
						nxt_s.txwr[wdec.p] = s_ff.ws != 2'b00;
						nxt_s.txd[wdec.p] = s_ff.wd[8:0];
					end
					ulp_pkg::K_RX: ;
					ulp_pkg::K_BRG: nxt_s.brg[wdec.p] = merge(
						s_ff.brg[wdec.p], s_ff.wd, s_ff.ws,
						ulp_pkg::BRG_WMASK);
					ulp_pkg::K_STAT: nxt_s.stat = s_ff.stat &
						~(s_ff.wd[3:0] & {4{s_ff.ws[0]}});
					ulp_pkg::K_MASK: if (s_ff.ws[0]) begin
						nxt_s.mask = s_ff.wd[3:0];
					end
					default: ;
				endcase
			end
		end
		nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
		// read: answer one cycle after the address is taken
		if (ARVALID && s_ff.arready) begin
			d = dec(ARADDR[13:2]);
			if (d.hit) begin
				unique case (d.kind)
					ulp_pkg::K_MODE: v = s_ff.mode[d.p];
					ulp_pkg::K_STA: begin
						v = s_ff.sta[d.p] & ulp_pkg::STA_WMASK;
						v[ulp_pkg::STA_TXBF] = tx_full[d.p];
						v[ulp_pkg::STA_SHIFTER_EMPTY_FLAG] = tx_empty[d.p];
						v[ulp_pkg::STA_RECEIVER_QUIET_FLAG] = !s_ff.act[d.p];
						v[ulp_pkg::STA_PARITY_FAULT_FLAG] = s_ff.parity_fault_flag[d.p];
						v[ulp_pkg::STA_STOP_BIT_FAULT_FLAG] = s_ff.stop_bit_fault_flag[d.p];
						v[ulp_pkg::STA_RX_OVERFLOW_FLAG] = s_ff.rx_overflow_flag[d.p];
						v[ulp_pkg::STA_RXDA] = s_ff.rxda[d.p];
					end
					ulp_pkg::K_TX: v = {7'h00, tx_hold[d.p]};
					ulp_pkg::K_RX: begin
						v = {7'h00, s_ff.rxw[d.p]};
						nxt_s.rxda[d.p] = 1'b0;
					end
					ulp_pkg::K_BRG: v = s_ff.brg[d.p];
					ulp_pkg::K_STAT: v = {12'h000, s_ff.stat};
					ulp_pkg::K_MASK: v = {12'h000, s_ff.mask};
					default: v = 16'h0000;
				endcase
			end
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = d.hit ? ulp_pkg::RESP_OKAY : ulp_pkg::RESP_SLVERR;
			nxt_s.rdata = {16'h0000, v};
			nxt_s.r_tx = d.hit && d.kind == ulp_pkg::K_TX;
		end
		nxt_s.arready = !nxt_s.rvalid;
		// receivers; hardware sets come after software clears
		for (int i = 0; i < 2; i++) begin
			pd = s_ff.mode[i][ulp_pkg::MODE_PD +: 2];
			src = s_ff.mode[i][ulp_pkg::MODE_LPBK] ? tx_line[i] :
				SERIAL_IN_LINE[i];
			if (SLEEP && s_ff.mode[i][ulp_pkg::MODE_EN] &&
				s_ff.mode[i][ulp_pkg::MODE_WAKE] && s_ff.prev[i] &&
				!SERIAL_IN_LINE[i]) begin
				nxt_s.stat[i] = 1'b1;
			end
			nxt_s.prev[i] = SERIAL_IN_LINE[i];
			if (!run[i]) begin
				nxt_s.act[i] = 1'b0;
				nxt_s.sub[i] = 4'h0;
				nxt_s.bitn[i] = 4'h0;
			end else if (tick[i] && !s_ff.act[i]) begin
				// start only after the line went high again
				if (src) begin
					nxt_s.whi[i] = 1'b0;
				end else if (!s_ff.whi[i] && !nxt_s.rx_overflow_flag[i]) begin
					nxt_s.act[i] = 1'b1;
					nxt_s.sub[i] = 4'h0;
					nxt_s.bitn[i] = 4'h0;
				end
			end else if (tick[i]) begin
				nxt_s.sub[i] = s_ff.sub[i] + 4'h1;
				if (s_ff.sub[i] == ulp_pkg::OVS_MID) begin
					if (s_ff.bitn[i] == 4'h0 && src) begin
						nxt_s.act[i] = 1'b0; // false start
					end else begin
						w = s_ff.sh[i];
						w[s_ff.bitn[i]] = src;
						nxt_s.sh[i] = w;
						len = ulp_pkg::frame_len(pd,
							s_ff.mode[i][ulp_pkg::MODE_ST]);
						if (s_ff.bitn[i] == len - 4'h1) begin
							nxt_s.act[i] = 1'b0;
							data = {pd == 2'b11 && w[9], w[8:1]};
							nxt_s.whi[i] = !src ||
								(s_ff.mode[i][ulp_pkg::MODE_ST] &&
								!w[len - 4'h2]);
							if (nxt_s.rxda[i]) begin
								nxt_s.rx_overflow_flag[i] = 1'b1;
							end else begin
								nxt_s.rxw[i] = data;
								nxt_s.rxda[i] = 1'b1;
								nxt_s.stop_bit_fault_flag[i] = nxt_s.whi[i];
								nxt_s.parity_fault_flag[i] = (pd == 2'b01 || pd == 2'b10)
									&& w[9] != ulp_pkg::ninth(pd, data);
								evt = (s_ff.sta[i][ulp_pkg::STA_ADDRESS_MATCH_ENABLE] &&
									pd == 2'b11) ? data[8] :
									!s_ff.sta[i][ulp_pkg::STA_RXSEL + 1];
								if (evt) begin
									nxt_s.stat[i] = 1'b1;
								end
							end
						end else begin
							nxt_s.bitn[i] = s_ff.bitn[i] + 4'h1;
						end
					end
				end
			end
			if (tx_load[i]) begin
				nxt_s.stat[i + 2] = 1'b1;
			end
		end
		nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
		nxt_s.wake = SLEEP && |(nxt_s.stat & nxt_s.mask & ulp_pkg::IRQ_RX);
	end

	// state register; sleep has no path here, so mode, sta, brg and rxw stay put
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign SERIAL_OUT_LINE = tx_line;
	assign IRQ = s_ff.irq;
	assign WAKE_REQ = s_ff.wake;
	assign AWREADY = s_ff.awready;
	assign WREADY = s_ff.wready;
	assign BVALID = s_ff.bvalid;
	assign BRESP = s_ff.bresp;
	assign ARREADY = s_ff.arready;
	assign RVALID = s_ff.rvalid;
	assign RRESP = s_ff.rresp;
	assign RDATA = s_ff.rdata;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	property p_tick_off;
		SLEEP |=> tick == 2'b00;
	endproperty
	a_tick_off: assert property (p_tick_off) else $error("tick in sleep");
	property p_rx_abort;
		SLEEP |=> s_ff.act == 2'b00;
	endproperty
	a_rx_abort: assert property (p_rx_abort) else $error("rx kept going");
	property p_keep;
		(SLEEP && !wr_commit) |=> $stable(s_ff.mode) && $stable(s_ff.brg)
			&& $stable(s_ff.sta) && $stable(s_ff.rxw);
	endproperty
	a_keep: assert property (p_keep) else $error("register lost in sleep");
	property p_wake;
		(SLEEP && s_ff.mode[0][ulp_pkg::MODE_EN] &&
			s_ff.mode[0][ulp_pkg::MODE_WAKE] && s_ff.prev[0] &&
			!SERIAL_IN_LINE[0]) |=> s_ff.stat[0];
	endproperty
	a_wake: assert property (p_wake) else $error("wake edge missed");
	property p_wake_sel;
		(SLEEP && s_ff.mode[0][ulp_pkg::MODE_EN] &&
			s_ff.mode[0][ulp_pkg::MODE_WAKE] && s_ff.prev[0] &&
			!SERIAL_IN_LINE[0] && s_ff.sta[0][ulp_pkg::STA_RXSEL + 1])
			|=> s_ff.stat[0];
	endproperty
	a_wake_sel: assert property (p_wake_sel) else $error("wake gated");
	property p_wake_out;
		(SLEEP && !wr_commit && |(s_ff.stat & s_ff.mask & ulp_pkg::IRQ_RX))
			|=> WAKE_REQ ##0 $past(SLEEP);
	endproperty
	a_wake_out: assert property (p_wake_out) else $error("no wake");
	property p_en;
		(!s_ff.mode[0][ulp_pkg::MODE_EN] && !s_ff.stat[0]) |=> !s_ff.stat[0];
	endproperty
	a_en: assert property (p_en) else $error("flag while disabled");
	property p_idle;
		(CPU_IDLE && s_ff.mode[0][ulp_pkg::MODE_SIDL]) |=> tick[0] == 1'b0;
	endproperty
	a_idle: assert property (p_idle) else $error("ran in idle");
	property p_idle_abort;
		(CPU_IDLE && s_ff.mode[0][ulp_pkg::MODE_SIDL]) |=> !s_ff.act[0];
	endproperty
	a_idle_abort: assert property (p_idle_abort) else $error("idle rx on");
	property p_rdzero;
		RVALID |-> RDATA[31:16] == 16'h0000 &&
			(s_ff.mode[0] & ~ulp_pkg::MODE_WMASK) == ulp_pkg::REG_RST;
	endproperty
	a_rdzero: assert property (p_rdzero) else $error("bits not zero");
	property p_txread;
		(RVALID && s_ff.r_tx) |-> RDATA[15:9] == 7'h00;
	endproperty
	a_txread: assert property (p_txread) else $error("send upper bits");
	property p_brg;
		(wr_commit && wdec.hit && wdec.kind == ulp_pkg::K_BRG &&
			s_ff.ws == 2'b11) |=> s_ff.brg[$past(wdec.p)] == $past(s_ff.wd);
	endproperty
	a_brg: assert property (p_brg) else $error("divider write lost");
	c_wake: cover property (SLEEP && $rose(s_ff.stat[0]));
	c_rxword: cover property ($rose(s_ff.rxda[0]));
	c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// File: tb/ulp_far_node.sv
// ulp_far_node: remote serial node, eight data bits, no parity, one stop.
// assumes bt is the bit time in clocks and calls start after a clock edge.
`default_nettype none
module ulp_far_node (
	input  wire logic clk,
	input  wire logic rx_line,
	output var  logic tx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// the line idles high between frames
	initial tx_line = 1'b1;
	// start bit, data lsb first, stop bit
	task automatic send(input logic [7:0] b, input int bt);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx_line <= f[i];
			repeat (bt) @(posedge clk);
		end
	endtask
	// catch one frame, sampled in the middle of each bit
	task automatic recv(output logic [7:0] b, input int bt);
		wait (rx_line === 1'b0);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge clk);
			b[i] = rx_line;
		end
	endtask
endmodule
`default_nettype wire

// File: tb/uart_low_power_and_register_map_test.sv
// bench of the two-port serial block: registers, transfer, sleep, idle.
// assumes port 1 faces ulp_far_node; the port 2 input idles high.
`default_nettype none
module uart_low_power_and_register_map_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        REF_CLK, ARST_N, SLEEP, CPU_IDLE, IRQ, WAKE_REQ, far_tx;
	logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY;
	logic [13:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, d;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, r, SERIAL_OUT_LINE;
	logic [7:0]  b;
	wire  logic [1:0] SERIAL_IN_LINE;
	int          err_count, num_checks;
	assign SERIAL_IN_LINE = {1'b1, far_tx};
	ulp_uart_top u_ulp_uart_top (.REF_CLK, .ARST_N, .SLEEP, .CPU_IDLE,
		.SERIAL_IN_LINE, .SERIAL_OUT_LINE, .IRQ, .WAKE_REQ, .AWADDR,
		.AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
		.BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
		.RVALID, .RREADY);
	ulp_far_node u_ulp_far_node (.clk(REF_CLK),
		.rx_line(SERIAL_OUT_LINE[0]), .tx_line(far_tx));
	// 25 MHz clock
	always #20 REF_CLK = ~REF_CLK;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// one write: address and data offered together, then the response
	task automatic wr(input logic [11:0] i, input logic [15:0] v);
		bit a, w;
		a = 0;
		w = 0;
		AWADDR <= {i, 2'b00};
		WDATA <= {16'h0000, v};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		forever begin
			@(posedge REF_CLK);
			if (!a && AWREADY) begin
				a = 1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY) begin
				w = 1;
				WVALID <= 1'b0;
			end
			if (BVALID) begin
				r = BRESP;
				break;
			end
		end
	endtask
	// one read, data and response taken at the handshake edge
	task automatic rd(input logic [11:0] i);
		bit a;
		a = 0;
		ARADDR <= {i, 2'b00};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		forever begin
			@(posedge REF_CLK);
			if (!a && ARREADY) begin
				a = 1;
				ARVALID <= 1'b0;
			end
			if (RVALID) begin
				d = RDATA;
				r = RRESP;
				break;
			end
		end
	endtask
	task automatic t_reset();
		rd(ulp_pkg::IDX_MODE1);
		chk(d, 32'h0000_0000);
		rd(ulp_pkg::IDX_STA1);
		chk(d, 32'h0000_0110);
		rd(ulp_pkg::IDX_BRG2);
		chk(d, 32'h0000_0000);
		rd(ulp_pkg::IDX_TX1);
		chk(d & 32'hffff_fe00, 32'h0000_0000);
		rd(12'h222);
		chk({30'h0, r}, {30'h0, ulp_pkg::RESP_SLVERR});
		wr(12'h222, 16'h0000);
		chk({30'h0, r}, {30'h0, ulp_pkg::RESP_SLVERR});
	endtask
	task automatic t_xfer();
		wr(ulp_pkg::IDX_BRG1, 16'hffff);
		rd(ulp_pkg::IDX_BRG1);
		chk(d, 32'h0000_ffff);
		wr(ulp_pkg::IDX_BRG1, 16'h0001);
		wr(ulp_pkg::IDX_MODE1, 16'h8000);
		wr(ulp_pkg::IDX_STA1, 16'h0400);
		wr(ulp_pkg::IDX_MASK, 16'h0001);
		CPU_IDLE <= 1'b1;
		wr(ulp_pkg::IDX_TX1, 16'h00a5);
		u_ulp_far_node.recv(b, 32);
		chk({24'h0, b}, 32'h0000_00a5);
		u_ulp_far_node.send(8'h3c, 32);
		repeat (40) @(posedge REF_CLK);
		chk({31'h0, IRQ}, 32'h1);
		rd(ulp_pkg::IDX_RX1);
		chk(d, 32'h0000_003c);
		CPU_IDLE <= 1'b0;
		wr(ulp_pkg::IDX_STAT, 16'h000f);
	endtask
	// sleep in mid-frame, then wake on a falling input edge
	task automatic t_sleep();
		wr(ulp_pkg::IDX_MODE1, 16'h8080);
		wr(ulp_pkg::IDX_STA1, 16'h04c0);
		wr(ulp_pkg::IDX_TX1, 16'h005a);
		// sleep falls inside both an outgoing and an incoming frame
		fork
			u_ulp_far_node.send(8'h00, 32);
			begin
				repeat (48) @(posedge REF_CLK);
				SLEEP <= 1'b1;
			end
		join
		chk({31'h0, SERIAL_OUT_LINE[0]}, 32'h1);
		chk({31'h0, SERIAL_OUT_LINE[1]}, 32'h1);
		chk({31'h0, IRQ}, 32'h0);
		u_ulp_far_node.send(8'hff, 32);
		chk({31'h0, IRQ}, 32'h1);
		chk({31'h0, WAKE_REQ}, 32'h1);
		SLEEP <= 1'b0;
		rd(ulp_pkg::IDX_BRG1);
		chk(d, 32'h0000_0001);
		rd(ulp_pkg::IDX_MODE1);
		chk(d, 32'h0000_8080);
		rd(ulp_pkg::IDX_STA1);
		chk(d, 32'h0000_05d0);
		wr(ulp_pkg::IDX_STAT, 16'h000f);
	endtask
	task automatic t_idle();
		wr(ulp_pkg::IDX_MODE1, 16'ha000);
		CPU_IDLE <= 1'b1;
		wr(ulp_pkg::IDX_TX1, 16'h0011);
		repeat (64) @(posedge REF_CLK);
		chk({31'h0, SERIAL_OUT_LINE[0]}, 32'h1);
		CPU_IDLE <= 1'b0;
		u_ulp_far_node.recv(b, 32);
		chk({24'h0, b}, 32'h0000_0011);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#(40 * 20000);
		err_count++;
		end_sim();
	end
	// reset, then the scenarios in turn
	initial begin
		{REF_CLK, ARST_N, SLEEP, CPU_IDLE, AWVALID, WVALID} = '0;
		{BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
		WSTRB = 4'hf;
		err_count = 0;
		num_checks = 0;
		repeat (6) @(posedge REF_CLK);
		ARST_N <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		t_reset();
		t_xfer();
		t_sleep();
		t_idle();
		end_sim();
	end
endmodule
`default_nettype wire
